// ==== src/pin_mux_consts.svh ====
// Register offsets, field positions, masks and reset values for the
// port pin function selector. Assumes an 8-bit register port, 5-bit address.
// Operation
// - Port-4 bits 5-7 are ports or drive address bits 21-23 per selection.
// - Capture channels 0-2 always sample their port-4 pins, whatever the selection.
// - Timer channels 0-2 always take event input from the same port-4 pins.
// - Port-5 bit 1 is a port, or the bus ready input when enabled.
// - Hold enabled: bit 3 takes hold request, bit 2 drives hold acknowledge.
// - Port-5 bit 4 drives upper write strobe only in 16-bit mode when enabled.
// - Port-5 bit 5 drives lower write strobe when enabled, else port.
// - Port-5 bit 6 is a port or the data read strobe output.
// - Flash mode: port-5 bits 4-7 become write, output, chip enable, byte inputs.
// - Port-5 bit 7 feeds capture channel 3 and external interrupt 3 always.
// - Open-drain pins with analog bit 0 read back the pin level.
// - Open-drain pins pull low for a 0 in the port data and release the pin for a 1.
// - Port-7 bit 0 outputs timer 0 when analog bit 0 and output enabled.
// - Port-7 bits 1 and 2 carry timer 1 and 2 outputs when enabled.
// - Port-7 bit 3 is a port unless serial 1 clock output is enabled.
// - Port-7 bit 4 stays a port; serial 1 receiver always samples it.
// - Port-7 bit 5 is a port while serial 1 data output is disabled.
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

`define REG_ADDR_W    5
`define REG_DATA_W    8

`define OFS_P4_DATA   5'h00
`define OFS_P5_DATA   5'h01
`define OFS_P6_DATA   5'h02
`define OFS_P7_DATA   5'h03
`define OFS_P4_DIR    5'h04
`define OFS_P5_DIR    5'h05
`define OFS_P7_DIR    5'h06
`define OFS_UPPER_AC  5'h07
`define OFS_BUS_CTL   5'h08
`define OFS_OUT_EN    5'h09
`define OFS_ANA_LO    5'h0A
`define OFS_ANA_HI    5'h0B
`define OFS_P6_LATCH  5'h0C
`define OFS_STATUS    5'h0D

`define P4_MASK       8'hE0
`define P5_MASK       8'hFE
`define P7_MASK       8'h3F
`define BUS_CTL_MASK  8'h3F
`define OUT_EN_MASK   8'h1F
`define ANA_HI_MASK   8'h01
`define RST_REG       8'h00
`define RD_NONE       8'h00

`define P4_LSB        5
`define BC_READY_EN   0
`define BC_HOLD_EN    1
`define BC_WRH_EN     2
`define BC_WRL_EN     3
`define BC_RD_EN      4
`define BC_BUS16      5
`define OE_TMR0       0
`define OE_TMR1       1
`define OE_TMR2       2
`define OE_SERIAL1_CLOCK_PIN       3
`define OE_SERIAL1_TRANSMIT_PIN       4
`define ST_FLASH      0

`define SYNC_W        25
`define SETTLE_CYC    2'h2

`endif

// ==== src/pin_mux_pkg.sv ====
// Types shared by the pin function selector files.
// Assumes the constants header sits on the include path.
`default_nettype none
`include "pin_mux_consts.svh"
package pin_mux_pkg;
    typedef logic [`REG_ADDR_W-1:0] reg_addr_type;
    typedef logic [`REG_DATA_W-1:0] reg_data_type;
endpackage
`default_nettype wire

// ==== src/pin_input_sync.sv ====
// Two-flop synchroniser bank for pin levels entering the mclk domain.
// Assumes each bit is an independent level; no bus coherency is kept.
`timescale 1ns/1ps
`default_nettype none
module pin_input_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rstn,
    // Raw and synchronised levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== src/open_drain_port.sv ====
// Open-drain analog-capable port bank: pin drive and read-back view.
// Assumes pin levels arrive already synchronised to mclk.
`timescale 1ns/1ps
`default_nettype none
module open_drain_port (
    // Port data latch and analog enables
    input  wire logic [7:0] latch,
    input  wire logic [7:0] ana,
    // Synchronised pin levels
    input  wire logic [7:0] pin_s,
    // Pin drive and normal read view
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe,
    output logic      [7:0] rd_view
);
    for (genvar i = 0; i < 8; i++) begin : g_bit
        // latch drives pin
        // Only pulls low; a 1 releases so an analog source is not loaded
        assign pin_out[i] = 1'b0;
        assign pin_oe[i]  = ~latch[i];
        assign rd_view[i] = ana[i] ? latch[i] : pin_s[i];
    end
endmodule
`default_nettype wire

// ==== src/port_pin_function_select.sv ====
// Pin function selector for port-4 upper bits and ports 5, 6 and 7.
// Assumes peripherals and bus controller run on mclk; pins are asynchronous.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pin_mux_consts.svh"
module port_pin_function_select
    import pin_mux_pkg::*;
(
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Register port
    input  wire reg_addr_type reg_addr,
    input  wire reg_data_type reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output reg_data_type      reg_rdata,
    // Chip mode level from the mode pins
    input  wire logic         flash_mode_pin,
    // Port 4 bits 5 to 7
    input  wire logic [2:0]   p4_in,
    output logic      [2:0]   p4_out,
    output logic      [2:0]   p4_oe,
    // Port 5 bits 1 to 7
    input  wire logic [7:1]   p5_in,
    output logic      [7:1]   p5_out,
    output logic      [7:1]   p5_oe,
    // Port 6 open-drain pins
    input  wire logic [7:0]   p6_in,
    output logic      [7:0]   p6_out,
    output logic      [7:0]   p6_oe,
    // Port 7 bits 0 to 5
    input  wire logic [5:0]   p7_in,
    output logic      [5:0]   p7_out,
    output logic      [5:0]   p7_oe,
    // External bus controller
    input  wire logic         addr_bit21_out,
    input  wire logic         addr_bit22_out,
    input  wire logic         addr_bit23_out,
    input  wire logic         hold_acknowledge_out,
    input  wire logic         upper_byte_store_strobe,
    input  wire logic         lower_byte_store_strobe,
    input  wire logic         data_read_strobe,
    output logic              bus_ready_in,
    output logic              hold_request_in,
    // Capture, timer and interrupt inputs
    output logic              capture0_input,
    output logic              capture1_input,
    output logic              capture2_input,
    output logic              capture3_input,
    output logic              timer0_event_input,
    output logic              timer1_event_input,
    output logic              timer2_event_input,
    output logic              ext_interrupt3_input,
    // Timer outputs
    input  wire logic         timer0_output,
    input  wire logic         timer1_output,
    input  wire logic         timer2_output,
    // Simple serial channel 1
    input  wire logic         serial1_clock_out,
    input  wire logic         serial1_transmit_data,
    output logic              serial1_clock_in,
    output logic              serial1_receive_data,
    // Flash programming controls, active low except byte mode
    output logic              flash_write_enable_n,
    output logic              flash_output_enable_n,
    output logic              flash_chip_enable_n,
    output logic              flash_byte_mode,
    // Analog enables towards the converter
    output logic      [8:0]   analog_enable_bits
);
    reg_data_type       p4_data_q;
    reg_data_type       p5_data_q;
    reg_data_type       p6_data_q;
    reg_data_type       p7_data_q;
    reg_data_type       p4_dir_q;
    reg_data_type       p5_dir_q;
    reg_data_type       p7_dir_q;
    reg_data_type       upper_ac_q;
    reg_data_type       bus_ctl_q;
    reg_data_type       out_en_q;
    reg_data_type       ana_lo_q;
    reg_data_type       ana_hi_q;
    reg_data_type       rdata_d;
    reg_data_type       rdata_q;
    logic [`SYNC_W-1:0] pins_raw;
    logic [`SYNC_W-1:0] pins_s;
    logic [2:0]         p4_s;
    logic [7:1]         p5_s;
    logic [7:0]         p6_s;
    logic [5:0]         p7_s;
    logic               flash_q;
    logic [7:0]         p6_rd_view;
    logic [2:0]         addr_hi;
    logic               p70_level;
    logic [1:0]         settle_q;

    // Every pin and the mode level cross into mclk through two flops
    assign pins_raw = {flash_mode_pin, p7_in, p6_in, p5_in, p4_in};

    pin_input_sync #(
        .WIDTH (`SYNC_W)
    ) u_sync (
        .mclk (mclk),
        .rstn (rstn),
        .d    (pins_raw),
        .q    (pins_s)
    );

    assign p4_s    = pins_s[2:0];
    assign p5_s    = pins_s[9:3];
    assign p6_s    = pins_s[17:10];
    assign p7_s    = pins_s[23:18];
    assign flash_q = pins_s[24];

    // Port data latches; unused bit positions are never stored
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            p4_data_q <= `RST_REG;
            p5_data_q <= `RST_REG;
            p6_data_q <= `RST_REG;
            p7_data_q <= `RST_REG;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_P4_DATA: p4_data_q <= reg_wdata & `P4_MASK;
                `OFS_P5_DATA: p5_data_q <= reg_wdata & `P5_MASK;
                `OFS_P6_DATA: p6_data_q <= reg_wdata;
                `OFS_P7_DATA: p7_data_q <= reg_wdata & `P7_MASK;
                default: ;
            endcase
        end
    end

    // Direction latches; reset leaves ports 4, 5 and 7 as input, except port-7 bit 0, which pulls low
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            p4_dir_q <= `RST_REG;
            p5_dir_q <= `RST_REG;
            p7_dir_q <= `RST_REG;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_P4_DIR: p4_dir_q <= reg_wdata & `P4_MASK;
                `OFS_P5_DIR: p5_dir_q <= reg_wdata & `P5_MASK;
                `OFS_P7_DIR: p7_dir_q <= reg_wdata & `P7_MASK;
                default: ;
            endcase
        end
    end

    // Function selects and analog enables
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            upper_ac_q <= `RST_REG;
            bus_ctl_q  <= `RST_REG;
            out_en_q   <= `RST_REG;
            ana_lo_q   <= `RST_REG;
            ana_hi_q   <= `RST_REG;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_UPPER_AC: upper_ac_q <= reg_wdata & `P4_MASK;
                `OFS_BUS_CTL:  bus_ctl_q  <= reg_wdata & `BUS_CTL_MASK;
                `OFS_OUT_EN:   out_en_q   <= reg_wdata & `OUT_EN_MASK;
                `OFS_ANA_LO:   ana_lo_q   <= reg_wdata;
                `OFS_ANA_HI:   ana_hi_q   <= reg_wdata & `ANA_HI_MASK;
                default: ;
            endcase
        end
    end

    // Read view: outputs read their latch, inputs read the pin
    always_comb begin
        case (reg_addr)
            `OFS_P4_DATA:  rdata_d = ((p4_dir_q & p4_data_q) | (~p4_dir_q & {p4_s, 5'h00})) & `P4_MASK;
            `OFS_P5_DATA:  rdata_d = ((p5_dir_q & p5_data_q) | (~p5_dir_q & {p5_s, 1'b0})) & `P5_MASK;
            `OFS_P6_DATA:  rdata_d = p6_rd_view;
            `OFS_P7_DATA:  rdata_d = ((p7_dir_q & p7_data_q) | (~p7_dir_q & {2'h0, p7_s})) & `P7_MASK;
            `OFS_P4_DIR:   rdata_d = p4_dir_q;
            `OFS_P5_DIR:   rdata_d = p5_dir_q;
            `OFS_P7_DIR:   rdata_d = p7_dir_q;
            `OFS_UPPER_AC: rdata_d = upper_ac_q;
            `OFS_BUS_CTL:  rdata_d = bus_ctl_q;
            `OFS_OUT_EN:   rdata_d = out_en_q;
            `OFS_ANA_LO:   rdata_d = ana_lo_q;
            `OFS_ANA_HI:   rdata_d = ana_hi_q;
            // Read-modify-write view of the open-drain latch
            `OFS_P6_LATCH: rdata_d = p6_data_q;
            `OFS_STATUS:   rdata_d = {7'h00, flash_q};
            default:       rdata_d = `RD_NONE;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= `RD_NONE;
        end else begin
            rdata_q <= reg_rd ? rdata_d : `RD_NONE;
        end
    end

    assign reg_rdata = rdata_q;

    // Port 4 upper pins: address or general port per bit
    assign addr_hi = {addr_bit23_out, addr_bit22_out, addr_bit21_out};

    for (genvar i = 0; i < 3; i++) begin : g_p4
        assign p4_out[i] = upper_ac_q[`P4_LSB + i] ? addr_hi[i] : p4_data_q[`P4_LSB + i];
        assign p4_oe[i]  = upper_ac_q[`P4_LSB + i] | p4_dir_q[`P4_LSB + i];
    end

    // capture always samples
    // No drive blocking: software must keep outputs off these pins
    assign capture0_input = p4_s[0];
    assign capture1_input = p4_s[1];
    assign capture2_input = p4_s[2];

    assign timer0_event_input = p4_s[0];
    assign timer1_event_input = p4_s[1];
    assign timer2_event_input = p4_s[2];

    // Port 5 pin selection; later branches take priority
    always_comb begin
        p5_out = p5_data_q[7:1];
        p5_oe  = p5_dir_q[7:1];
        if (bus_ctl_q[`BC_READY_EN]) begin
            p5_oe[1] = 1'b0;
        end
        if (bus_ctl_q[`BC_HOLD_EN]) begin
            p5_out[2] = hold_acknowledge_out;
            p5_oe[2]  = 1'b1;
            p5_oe[3]  = 1'b0;
        end
        if (bus_ctl_q[`BC_BUS16] && bus_ctl_q[`BC_WRH_EN]) begin
            p5_out[4] = upper_byte_store_strobe;
            p5_oe[4]  = 1'b1;
        end
        if (bus_ctl_q[`BC_WRL_EN]) begin
            p5_out[5] = lower_byte_store_strobe;
            p5_oe[5]  = 1'b1;
        end
        if (bus_ctl_q[`BC_RD_EN]) begin
            p5_out[6] = data_read_strobe;
            p5_oe[6]  = 1'b1;
        end
        if (flash_q) begin
            p5_oe[7:4] = 4'h0;
        end
    end

    // Bus ready idles high and hold request idles low when their function is off
    assign bus_ready_in    = bus_ctl_q[`BC_READY_EN] ? p5_s[1] : 1'b1;
    assign hold_request_in = bus_ctl_q[`BC_HOLD_EN] & p5_s[3];

    assign capture3_input       = p5_s[7];
    assign ext_interrupt3_input = p5_s[7];

    assign flash_write_enable_n  = flash_q ? p5_s[4] : 1'b1;
    assign flash_output_enable_n = flash_q ? p5_s[5] : 1'b1;
    assign flash_chip_enable_n   = flash_q ? p5_s[6] : 1'b1;
    assign flash_byte_mode       = flash_q & p5_s[7];

    // Port 6 open-drain bank
    open_drain_port u_p6 (
        .latch   (p6_data_q),
        .ana     (ana_lo_q),
        .pin_s   (p6_s),
        .pin_out (p6_out),
        .pin_oe  (p6_oe),
        .rd_view (p6_rd_view)
    );

    assign analog_enable_bits = {ana_hi_q[0], ana_lo_q};

    // timer 0 on open-drain pin
    // Pin only pulls low, so a high timer level simply releases it
    assign p70_level = (!ana_hi_q[0] && out_en_q[`OE_TMR0]) ? timer0_output : p7_data_q[0];

    // Port 7 pin selection
    always_comb begin
        p7_out    = p7_data_q[5:0];
        p7_oe     = p7_dir_q[5:0];
        p7_out[0] = 1'b0;
        p7_oe[0]  = ~p70_level;
        if (out_en_q[`OE_TMR1]) begin
            p7_out[1] = timer1_output;
            p7_oe[1]  = 1'b1;
        end
        if (out_en_q[`OE_TMR2]) begin
            p7_out[2] = timer2_output;
            p7_oe[2]  = 1'b1;
        end
        if (out_en_q[`OE_SERIAL1_CLOCK_PIN]) begin
            p7_out[3] = serial1_clock_out;
            p7_oe[3]  = 1'b1;
        end
        if (out_en_q[`OE_SERIAL1_TRANSMIT_PIN]) begin
            p7_out[5] = serial1_transmit_data;
            p7_oe[5]  = 1'b1;
        end
    end

    assign serial1_clock_in     = p7_s[3];
    assign serial1_receive_data = p7_s[4];

    // Cycles since reset release, so pipeline checks skip the fill
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            settle_q <= 2'h0;
        end else if (settle_q != `SETTLE_CYC) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    property p_addr_select;
        upper_ac_q[`P4_LSB] |-> p4_oe[0] && (p4_out[0] == addr_bit21_out);
    endproperty
    a_addr_select: assert property (p_addr_select) else $error("pin 45 not on address");

    property p_capture_delay;
        (settle_q == `SETTLE_CYC) |-> (capture1_input == $past(p4_in[1], 2));
    endproperty
    a_capture_delay: assert property (p_capture_delay) else $error("capture 1 lags wrongly");

    property p_timer_event;
        (settle_q == `SETTLE_CYC) |-> (timer2_event_input == $past(p4_in[2], 2))
            && (timer0_event_input == capture0_input);
    endproperty
    a_timer_event: assert property (p_timer_event) else $error("timer event input wrong");

    property p_ready_pin;
        bus_ctl_q[`BC_READY_EN] |-> !p5_oe[1] && (bus_ready_in == p5_s[1]);
    endproperty
    a_ready_pin: assert property (p_ready_pin) else $error("ready pin still driven");

    property p_hold_pins;
        bus_ctl_q[`BC_HOLD_EN] |-> p5_oe[2] && !p5_oe[3] && (p5_out[2] == hold_acknowledge_out);
    endproperty
    a_hold_pins: assert property (p_hold_pins) else $error("hold pins misrouted");

    property p_upper_strobe;
        (!flash_q && !bus_ctl_q[`BC_BUS16]) |-> (p5_oe[4] == p5_dir_q[4]) && (p5_out[4] == p5_data_q[4]);
    endproperty
    a_upper_strobe: assert property (p_upper_strobe) else $error("upper strobe in 8-bit mode");

    property p_lower_strobe;
        (!flash_q && bus_ctl_q[`BC_WRL_EN]) |-> p5_oe[5] && (p5_out[5] == lower_byte_store_strobe);
    endproperty
    a_lower_strobe: assert property (p_lower_strobe) else $error("lower strobe not driven");

    property p_flash_release;
        $rose(flash_q) |-> (p5_oe[7:4] == 4'h0) [*2];
    endproperty
    a_flash_release: assert property (p_flash_release) else $error("flash pins still driven");

    property p_ext_interrupt3_input_feed;
        ext_interrupt3_input == capture3_input;
    endproperty
    a_ext_interrupt3_input_feed: assert property (p_ext_interrupt3_input_feed) else $error("interrupt 3 differs from capture 3");

    property p_od_drive;
        reg_wr && (reg_addr == `OFS_P6_DATA) |=> (p6_oe == ~$past(reg_wdata));
    endproperty
    a_od_drive: assert property (p_od_drive) else $error("open-drain drive off latch");

    property p_od_read;
        reg_rd && (reg_addr == `OFS_P6_DATA) && (ana_lo_q == 8'h00) |=> (reg_rdata == $past(p6_s));
    endproperty
    a_od_read: assert property (p_od_read) else $error("port 6 read not pin level");

    property p_timer0_pin;
        (!ana_hi_q[0] && out_en_q[`OE_TMR0]) |-> (p7_oe[0] == !timer0_output);
    endproperty
    a_timer0_pin: assert property (p_timer0_pin) else $error("timer 0 not on pin 70");

    property p_serial_tx;
        out_en_q[`OE_SERIAL1_TRANSMIT_PIN] |-> p7_oe[5] && (p7_out[5] == serial1_transmit_data);
    endproperty
    a_serial_tx: assert property (p_serial_tx) else $error("serial transmit not driven");

    property p_ctl_write;
        reg_wr && (reg_addr == `OFS_BUS_CTL) |=> (bus_ctl_q == ($past(reg_wdata) & `BUS_CTL_MASK));
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("bus control write lost");

    c_hold_on: cover property (bus_ctl_q[`BC_HOLD_EN] && p5_s[3]);
    c_flash_entry: cover property ($rose(flash_q));
    c_addr_all: cover property (upper_ac_q == `P4_MASK);
    c_serial_both: cover property (out_en_q[`OE_SERIAL1_CLOCK_PIN] && out_en_q[`OE_SERIAL1_TRANSMIT_PIN]);
endmodule
`default_nettype wire

// ==== dv/board_model.sv ====
// Board side of the selector pins: external sources and pull-ups.
// Assumes pin vectors packed as port7, port6, port5 bits 1-7, port4 bits 5-7.
`timescale 1ns/1ps
`default_nettype none
module board_model (
    // Device drive
    input  wire logic [23:0] dev_out,
    input  wire logic [23:0] dev_oe,
    // Board sources
    input  wire logic [23:0] src_en,
    input  wire logic [23:0] src_val,
    // Resolved pin levels
    output logic      [23:0] pin
);
    // Released pins take an enabled board source, else the pull-up, never a stale level
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            pin[i] = dev_oe[i] ? dev_out[i] : (src_en[i] ? src_val[i] : 1'h1);
        end
    end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Directed bench for the pin function selector.
// Assumes the board model resolves pins; register port never waits.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pin_mux_pkg::*;
;
    logic         mclk, rstn, reg_wr, reg_rd, flash_mode_pin;
    reg_addr_type reg_addr;
    reg_data_type reg_wdata, reg_rdata, d;
    logic [2:0]   p4_out, p4_oe;
    logic [7:1]   p5_out, p5_oe;
    logic [7:0]   p6_out, p6_oe;
    logic [5:0]   p7_out, p7_oe;
    logic [23:0]  pin, src_en, src_val;
    logic [11:0]  pv;
    logic [8:0]   analog_enable_bits;
    logic         bus_ready_in, hold_request_in, capture0_input, capture1_input, capture2_input;
    logic         capture3_input, timer0_event_input, timer1_event_input, timer2_event_input;
    logic         ext_interrupt3_input, serial1_clock_in, serial1_receive_data, flash_byte_mode;
    logic         flash_write_enable_n, flash_output_enable_n, flash_chip_enable_n;
    int           n_errors = 0;
    int           n_tests = 0;

    port_pin_function_select dut (
        .mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_mode_pin,
        .p4_in(pin[2:0]), .p4_out, .p4_oe, .p5_in(pin[9:3]), .p5_out, .p5_oe,
        .p6_in(pin[17:10]), .p6_out, .p6_oe, .p7_in(pin[23:18]), .p7_out, .p7_oe,
        .addr_bit21_out(pv[0]), .addr_bit22_out(pv[1]), .addr_bit23_out(pv[2]),
        .hold_acknowledge_out(pv[3]), .upper_byte_store_strobe(pv[4]),
        .lower_byte_store_strobe(pv[5]), .data_read_strobe(pv[6]), .timer0_output(pv[7]),
        .timer1_output(pv[8]), .timer2_output(pv[9]), .serial1_clock_out(pv[10]),
        .serial1_transmit_data(pv[11]), .bus_ready_in, .hold_request_in, .capture0_input,
        .capture1_input, .capture2_input, .capture3_input, .timer0_event_input,
        .timer1_event_input, .timer2_event_input, .ext_interrupt3_input, .serial1_clock_in,
        .serial1_receive_data, .flash_write_enable_n, .flash_output_enable_n,
        .flash_chip_enable_n, .flash_byte_mode, .analog_enable_bits
    );
    board_model board (
        .dev_out({p7_out, p6_out, p5_out, p4_out}), .dev_oe({p7_oe, p6_oe, p5_oe, p4_oe}),
        .src_en, .src_val, .pin
    );

    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input reg_addr_type a, input reg_data_type v);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input reg_addr_type a);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask
    // Pins need two sync edges, so callers allow three
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // 250 MHz clock
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    // Whole run is under a hundred cycles; the limit is 10000 cycles
    initial begin
        #40000;
        n_errors++;
        stop_test();
    end

    initial begin
        rstn = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = '0;
        reg_wdata = '0;
        flash_mode_pin = 1'h0;
        src_en = '0;
        src_val = '0;
        pv = 12'hA5D;
        step(4);
        chk(p5_oe, 7'h00);
        chk(p6_oe, 8'hFF);
        @(posedge mclk) rstn <= 1'h1;
        // Address select, samplers still see the pins
        wr(5'h07, 8'hE0);
        step(3);
        chk({p4_oe, p4_out}, {3'h7, pv[2:0]});
        chk({capture2_input, capture1_input, capture0_input}, pv[2:0]);
        chk({timer2_event_input, timer1_event_input, timer0_event_input}, pv[2:0]);
        wr(5'h07, 8'h00);
        src_en <= 24'h000007;
        src_val <= 24'h000002;
        step(3);
        chk(p4_oe, 3'h0);
        chk({capture2_input, capture1_input, capture0_input}, 3'h2);
        // Ready and hold handshake
        wr(5'h08, 8'h03);
        src_en <= 24'h000028;
        src_val <= 24'h000020;
        step(3);
        chk(bus_ready_in, 1'h0);
        chk({hold_request_in, p5_oe[3:2], p5_out[2]}, {3'h5, pv[3]});
        wr(5'h08, 8'h00);
        step(3);
        chk({bus_ready_in, hold_request_in, p5_oe[3:1]}, 5'h10);
        // Strobes; upper strobe needs 16-bit mode
        wr(5'h08, 8'h1C);
        step(0);
        chk({p5_oe[6:4], p5_out[6:5]}, {3'h6, pv[6:5]});
        wr(5'h08, 8'h3C);
        step(0);
        chk({p5_oe[6:4], p5_out[4]}, {3'h7, pv[4]});
        // Flash mode takes over port-5 bits 4 to 7
        @(posedge mclk);
        flash_mode_pin <= 1'h1;
        src_en <= 24'h0003C0;
        src_val <= 24'h000280;
        // Mode level crosses two flops, then the released pins cross two more
        step(4);
        chk(p5_oe[7:4], 4'h0);
        chk({flash_byte_mode, flash_chip_enable_n, flash_output_enable_n, flash_write_enable_n}, 4'hA);
        chk({capture3_input, ext_interrupt3_input}, 2'h3);
        rd(5'h0D);
        chk(d, 8'h01);
        @(posedge mclk);
        flash_mode_pin <= 1'h0;
        step(3);
        chk({p5_oe[6:4], flash_write_enable_n}, 4'hF);
        // Open-drain bank, one released pin pulled low by the board
        wr(5'h02, 8'h0F);
        src_en <= 24'h000400;
        src_val <= 24'h000000;
        step(3);
        chk({p6_oe, p6_out}, {8'hF0, 8'h00});
        rd(5'h02);
        chk(d, 8'h0E);
        // Analog use: enable bit and data bit both set
        wr(5'h0A, 8'h01);
        rd(5'h02);
        chk(d, 8'h0F);
        chk({analog_enable_bits, p6_oe[0]}, 10'h002);
        // Port 7 outputs
        wr(5'h03, 8'h01);
        wr(5'h09, 8'h1F);
        step(0);
        chk(p7_oe[0], !pv[7]);
        chk({p7_oe[5:1], p7_out[5:1]}, {5'h17, pv[11], 1'h0, pv[10:8]});
        wr(5'h0B, 8'h01);
        step(0);
        chk(p7_oe[0], 1'h0);
        wr(5'h09, 8'h00);
        src_en <= 24'h600000;
        src_val <= 24'h400000;
        step(3);
        chk(p7_oe[5:1], 5'h00);
        chk({serial1_receive_data, serial1_clock_in}, 2'h2);
        // Port-5 bit 1 as driven general port, then the port 6 latch view
        wr(5'h05, 8'h02);
        wr(5'h01, 8'h02);
        step(0);
        chk({p5_oe[1], p5_out[1]}, 2'h3);
        rd(5'h01);
        chk(d, 8'hDE);
        rd(5'h0C);
        chk(d, 8'h0F);
        // Unmapped and read-only places
        wr(5'h0D, 8'hFF);
        rd(5'h0D);
        chk(d, 8'h00);
        rd(5'h1F);
        chk(d, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
